// file: pkg/flash_erase_pkg.sv
/*
 * Shared constants, types and decoding for the serial flash erase link.
 * Assumes both ends compile this package first.
 */
package flash_erase_pkg;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] CMD_HALF_BLOCK_ERASE_WIDE = 8'h53;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] CMD_BLOCK_ERASE_WIDE = 8'hDC;
    localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR_NARROW_BITS = 6'h18;
    localparam logic [5:0] ADDR_WIDE_BITS = 6'h20;
    localparam int HALF_SEL_BIT = 15;
    localparam int BLOCK_LSB = 16;
    localparam int STAT_WIP = 0;
    localparam int STAT_WEL = 1;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam int CFG_WIDE = 0;
    localparam int CFG_QUAD = 1;
    localparam int INT_DONE = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_PREPROGRAM = 2'b01,
        OP_ERASE = 2'b10
    } array_op_type;
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_LOW = 2'b01,
        LS_HIGH = 2'b10,
        LS_GAP = 2'b11
    } link_state_type;

    // address bits that follow an opcode
    function automatic logic [5:0] cmd_addr_bits(input logic [7:0] opc, input logic wide);
        logic [5:0] bits;
        bits = 6'h00;
        if (opc == CMD_HALF_BLOCK_ERASE || opc == CMD_BLOCK_ERASE) begin
            bits = wide ? ADDR_WIDE_BITS : ADDR_NARROW_BITS;
        end else if (opc == CMD_HALF_BLOCK_ERASE_WIDE || opc == CMD_BLOCK_ERASE_WIDE) begin
            bits = ADDR_WIDE_BITS;
        end
        return bits;
    endfunction : cmd_addr_bits
endpackage : flash_erase_pkg

// file: pkg/flash_link_if.sv
/*
 * Serial flash link between host controller and flash device.
 * Assumes the bench joins the two modports; data lines are host driven here.
 */
`timescale 1ns/1ps
interface flash_link_if;
    logic sclk;
    logic cs_n;
    logic [3:0] io;
    logic [3:0] io_oe;
    modport host (output sclk, output cs_n, output io, output io_oe);
    modport device (input sclk, input cs_n, input io, input io_oe);
endinterface : flash_link_if

// file: design/flash_erase_device.sv
/*
 * Flash device end: decodes erase frames, checks latch and protection,
 * then steps a self-timed pre-program/erase walk over the chosen sectors.
 * Assumes link pins are asynchronous to aclk and slow against it.
 */
`timescale 1ns/1ps
module flash_erase_device
    import flash_erase_pkg::*;
#(
    parameter int BLOCKS = 512,
    parameter int PHASE_CYCLES = 64,
    localparam int SECT_W = $clog2(BLOCKS * 16)
) (
    input wire logic aclk,
    input wire logic aresetn,
    flash_link_if.device link,
    input wire logic address_length_select,
    input wire logic quad_command_mode,
    input wire logic [2*BLOCKS-1:0] half_block_protected,
    output logic [7:0] status1,
    output logic erase_error,
    output logic erase_done,
    output array_op_type array_op,
    output logic [SECT_W-1:0] array_sector
);
    localparam int BW = $clog2(BLOCKS);
    localparam int TW = $clog2(PHASE_CYCLES + 1);

    logic [5:0] sync1_q, sync2_q;
    logic [1:0] last_q;
    logic [39:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic wel_q, busy_q, err_q, done_q;
    logic [SECT_W-1:0] cur_q, last_sect_q;
    array_op_type phase_q;
    logic [TW-1:0] timer_q;

    // synchronised link pins: {sclk, cs_n, io}
    wire sclk_s = sync2_q[5];
    wire cs_n_s = sync2_q[4];
    wire [3:0] io_s = sync2_q[3:0];
    wire sclk_rise = sclk_s & ~last_q[1];
    wire cs_rise = cs_n_s & ~last_q[0];
    wire sample = sclk_rise & ~cs_n_s;
    wire [5:0] step = quad_command_mode ? 6'h04 : 6'h01;
    wire [5:0] cnt_sum = bit_cnt_q + step;
    wire [5:0] cnt_next = (cnt_sum < bit_cnt_q) ? 6'h3F : cnt_sum;

    // frame decode at select rise
    wire [7:0] opc = (bit_cnt_q == OPCODE_BITS + ADDR_WIDE_BITS) ? shift_q[39:32] :
        (bit_cnt_q == OPCODE_BITS + ADDR_NARROW_BITS) ? shift_q[31:24] : shift_q[7:0];
    wire [31:0] addr = (bit_cnt_q == OPCODE_BITS + ADDR_WIDE_BITS) ? shift_q[31:0] :
        {8'h00, shift_q[23:0]};
    wire [5:0] need_bits = OPCODE_BITS + cmd_addr_bits(opc, address_length_select);
    wire exact = (bit_cnt_q == need_bits);
    wire is_half = (opc == CMD_HALF_BLOCK_ERASE) || (opc == CMD_HALF_BLOCK_ERASE_WIDE);
    wire is_block = (opc == CMD_BLOCK_ERASE) || (opc == CMD_BLOCK_ERASE_WIDE);
    wire is_chip = (opc == CMD_CHIP_ERASE_A) || (opc == CMD_CHIP_ERASE_B);
    wire is_write_enable_cmd = (opc == CMD_WRITE_ENABLE) && (bit_cnt_q == OPCODE_BITS);
    wire [BW-1:0] blk = addr[BLOCK_LSB+BW-1:BLOCK_LSB];
    wire [BW:0] half_idx = {blk, addr[HALF_SEL_BIT]};
    wire prot_half = half_block_protected[half_idx];
    wire prot_block = |half_block_protected[{blk, 1'b0} +: 2];
    wire prot_chip = |half_block_protected;
    wire prot_hit = is_half ? prot_half : is_block ? prot_block : prot_chip;
    wire erase_cmd = (is_half || is_block || is_chip) && exact;
    wire accept = cs_rise && !busy_q && wel_q && erase_cmd;
    wire go = accept && !prot_hit;
    wire refuse = accept && prot_hit;

    // sector range of the accepted command
    wire [SECT_W-1:0] first_sect = is_half ? {half_idx, 3'b000} :
        is_block ? {blk, 4'b0000} : '0;
    wire [SECT_W-1:0] last_sect = is_half ? {half_idx, 3'b111} :
        is_block ? {blk, 4'b1111} : '1;

    wire phase_end = busy_q && (timer_q == TW'(PHASE_CYCLES - 1));
    wire walk_end = phase_end && (phase_q == OP_ERASE) && (cur_q == last_sect_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 6'h10;
            sync2_q <= 6'h10;
            last_q <= 2'b01;
        end else begin
            sync1_q <= {link.sclk, link.cs_n, link.io};
            sync2_q <= sync1_q;
            last_q <= {sclk_s, cs_n_s};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= 40'h0;
            bit_cnt_q <= 6'h00;
        end else if (cs_n_s) begin
            bit_cnt_q <= 6'h00;
        end else if (sample) begin
            shift_q <= quad_command_mode ? {shift_q[35:0], io_s} : {shift_q[38:0], io_s[0]};
            bit_cnt_q <= cnt_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wel_q <= 1'b0;
            err_q <= 1'b0;
        end else if (cs_rise && !busy_q && is_write_enable_cmd) begin
            wel_q <= 1'b1;
            err_q <= 1'b0;
        end else if (refuse) begin
            wel_q <= 1'b0;
            err_q <= 1'b1;
        end else if (walk_end) begin
            wel_q <= 1'b0;
        end
    end

    // erase walk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            phase_q <= OP_IDLE;
            cur_q <= '0;
            last_sect_q <= '0;
            timer_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= walk_end;
            if (go) begin
                busy_q <= 1'b1;
                phase_q <= OP_PREPROGRAM;
                cur_q <= first_sect;
                last_sect_q <= last_sect;
                timer_q <= '0;
            end else if (phase_end) begin
                timer_q <= '0;
                if (phase_q == OP_PREPROGRAM) begin
                    phase_q <= OP_ERASE;
                end else if (walk_end) begin
                    busy_q <= 1'b0;
                    phase_q <= OP_IDLE;
                end else begin
                    cur_q <= cur_q + 1'b1;
                    phase_q <= OP_PREPROGRAM;
                end
            end else if (busy_q) begin
                timer_q <= timer_q + 1'b1;
            end
        end
    end

    always_comb begin
        status1 = 8'h00;
        status1[STAT_WIP] = busy_q;
        status1[STAT_WEL] = wel_q;
    end
    assign erase_error = err_q;
    assign erase_done = done_q;
    assign array_op = phase_q;
    assign array_sector = cur_q;
endmodule : flash_erase_device

// file: design/flash_erase_host.sv
/*
 * Host controller end: AXI4-Lite register slave that sends write-enable
 * and erase frames over the serial link, single or quad, msb first.
 * Assumes the device samples the link through its own synchronisers.
 */
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module flash_erase_host
    import flash_erase_pkg::*;
#(
    parameter int HALF_DIV = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    flash_link_if.host link
);
    localparam int DW = $clog2(HALF_DIV + 1);

    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] opc_q;
    logic [31:0] addr_q;
    logic [1:0] cfg_q;
    logic int_stat_q, int_mask_q;
    link_state_type state_q;
    logic [DW-1:0] div_q;
    logic [39:0] shift_q;
    logic [5:0] edges_q;
    logic quad_q, sclk_q, cs_n_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = val[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    wire busy = (state_q != LS_IDLE);
    wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
    wire [31:0] wmerged = merge(32'h0, wdata_q, wstrb_q);
    wire wr_cmd = do_write && (awaddr_q == REG_CMD);
    wire wr_addr = do_write && (awaddr_q == REG_ADDR);
    wire wr_cfg = do_write && (awaddr_q == REG_CFG);
    wire wr_istat = do_write && (awaddr_q == REG_INT_STAT);
    wire wr_imask = do_write && (awaddr_q == REG_INT_MASK);
    wire wr_ok = wr_cmd || wr_addr || wr_cfg || wr_istat || wr_imask;
    wire s_axi_wstrb_ok = wstrb_q[0];
    wire launch = wr_cmd && !busy && s_axi_wstrb_ok;
    wire ar_take = s_axi_arvalid && !rvalid_q;
    wire rd_ok = (s_axi_araddr <= REG_INT_MASK) && (s_axi_araddr[1:0] == 2'b00);
    wire [31:0] rd_mux = (s_axi_araddr == REG_CMD) ? {24'h0, opc_q} :
        (s_axi_araddr == REG_ADDR) ? addr_q :
        (s_axi_araddr == REG_CFG) ? {30'h0, cfg_q} :
        (s_axi_araddr == REG_STATUS) ? {31'h0, busy} :
        (s_axi_araddr == REG_INT_STAT) ? {31'h0, int_stat_q} :
        (s_axi_araddr == REG_INT_MASK) ? {31'h0, int_mask_q} : 32'h0;

    // frame built from opcode and address length
    wire [7:0] new_opc = wmerged[7:0];
    wire [5:0] abits = cmd_addr_bits(new_opc, cfg_q[CFG_WIDE]);
    wire [5:0] fbits = OPCODE_BITS + abits;
    wire [39:0] frame = (abits == ADDR_WIDE_BITS) ? {new_opc, addr_q} :
        (abits == ADDR_NARROW_BITS) ? {new_opc, addr_q[23:0], 8'h00} : {new_opc, 32'h0};
    wire tick = busy && (div_q == DW'(HALF_DIV - 1));
    wire frame_done = tick && (state_q == LS_GAP);

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= 32'h0;
            cfg_q <= 2'b00;
            int_stat_q <= 1'b0;
            int_mask_q <= 1'b0;
        end else begin
            if (wr_addr) begin
                addr_q <= merge(addr_q, wdata_q, wstrb_q);
            end
            if (wr_cfg && wstrb_q[0]) begin
                cfg_q <= wdata_q[1:0];
            end
            if (wr_imask && wstrb_q[0]) begin
                int_mask_q <= wdata_q[INT_DONE];
            end
            // set wins over write-one-to-clear
            int_stat_q <= frame_done | (int_stat_q & ~(wr_istat & wstrb_q[0] & wdata_q[INT_DONE]));
        end
    end

    // link engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= LS_IDLE;
            div_q <= '0;
            shift_q <= 40'h0;
            edges_q <= 6'h00;
            opc_q <= 8'h00;
            quad_q <= 1'b0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else if (launch) begin
            opc_q <= new_opc;
            shift_q <= frame;
            quad_q <= cfg_q[CFG_QUAD];
            edges_q <= cfg_q[CFG_QUAD] ? {2'b00, fbits[5:2]} : fbits;
            cs_n_q <= 1'b0;
            div_q <= '0;
            state_q <= LS_LOW;
        end else if (tick) begin
            div_q <= '0;
            unique case (state_q)
                LS_LOW: begin
                    sclk_q <= 1'b1;
                    state_q <= LS_HIGH;
                end
                LS_HIGH: begin
                    sclk_q <= 1'b0;
                    edges_q <= edges_q - 6'h01;
                    shift_q <= quad_q ? {shift_q[35:0], 4'h0} : {shift_q[38:0], 1'b0};
                    if (edges_q == 6'h01) begin
                        cs_n_q <= 1'b1;
                        state_q <= LS_GAP;
                    end else begin
                        state_q <= LS_LOW;
                    end
                end
                LS_GAP: begin
                    state_q <= LS_IDLE;
                end
                LS_IDLE: begin
                    state_q <= LS_IDLE;
                end
            endcase
        end else if (busy) begin
            div_q <= div_q + 1'b1;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = int_stat_q & int_mask_q;
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.io = quad_q ? shift_q[39:36] : {3'b000, shift_q[39]};
    assign link.io_oe = cs_n_q ? 4'h0 : (quad_q ? 4'hF : 4'h1);
endmodule : flash_erase_host

// file: sim/flash_erase_props.sv
/*
 * Assertions on the erase link pins and on the device's walk outputs.
 * Assumes tb_top instantiates it beside the link, clocked by aclk.
 */
`timescale 1ns/1ps
module flash_erase_props
    import flash_erase_pkg::*;
#(
    parameter int PHASE_CYCLES = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io,
    input wire logic [3:0] io_oe,
    input wire logic [7:0] status1,
    input wire logic erase_error,
    input wire logic erase_done,
    input wire array_op_type array_op
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // length of the current walk phase
    array_op_type prev_q;
    logic [15:0] run_q;
    always_ff @(posedge aclk) begin
        prev_q <= array_op;
        run_q <= (array_op == prev_q) ? run_q + 16'h0001 : 16'h0001;
    end
    a_oe_mode: assert property (!cs_n |-> io_oe == 4'h1 || io_oe == 4'hF)
        else $error("link enables neither single nor quad");
    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_io_hold_high: assert property (sclk && $past(sclk) |-> $stable(io))
        else $error("data moved while serial clock high");
    a_select_at_fall: assert property ($rose(cs_n) |-> $fell(sclk))
        else $error("select rose away from last clock fall");
    a_busy_in_walk: assert property (array_op != OP_IDLE |-> status1[STAT_WIP])
        else $error("array busy without progress flag");
    a_walk_starts_pre: assert property (prev_q == OP_IDLE && array_op != OP_IDLE |->
        array_op == OP_PREPROGRAM)
        else $error("walk began without pre-program");
    a_phase_length: assert property (prev_q == OP_PREPROGRAM && array_op != OP_PREPROGRAM |->
        array_op == OP_ERASE && run_q == PHASE_CYCLES)
        else $error("pre-program phase wrong length or not followed by erase");
    a_done_clears: assert property (erase_done |-> status1[1:0] == 2'b00 ##1 !erase_done)
        else $error("done pulse with flags still set");
    a_error_no_walk: assert property ($rose(erase_error) |-> array_op == OP_IDLE &&
        !status1[STAT_WIP])
        else $error("refused erase still walking");
    a_wip_on_select: assert property ($rose(status1[STAT_WIP]) |-> cs_n && $past(cs_n, 2))
        else $error("progress flag rose inside a frame");
endmodule : flash_erase_props

// file: sim/tb_top.sv
/*
 * Bench: host over AXI4-Lite driving a device, and a second device fed
 * by a bench driver that breaks framing. Assumes package, link and ends.
 */
`timescale 1ns/1ps
module tb_top;
    import flash_erase_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic bready = 1'b1;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, first_sect;
    logic wide = 1'b0;
    logic quad = 1'b0;
    logic [7:0] prot = 8'h00;
    logic [7:0] status1, status1_b;
    logic erase_error, erase_done, cs_q, sclk_q;
    array_op_type array_op, op_q;
    logic [5:0] array_sector;
    logic sclk_b = 1'b0;
    logic cs_b = 1'b1;
    logic [3:0] io_b = 4'h0;
    logic [39:0] cap;
    int nbits, n_sect, fails, samples_checked;
    flash_link_if link();
    flash_link_if link_b();
    assign link_b.sclk = sclk_b;
    assign link_b.cs_n = cs_b;
    assign link_b.io = io_b;
    assign link_b.io_oe = cs_b ? 4'h0 : 4'h1;
    always #4 aclk = ~aclk;
    flash_erase_host u_flash_erase_host (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .link(link));
    flash_erase_device #(.BLOCKS(4), .PHASE_CYCLES(4)) u_flash_erase_device (.aclk(aclk),
        .aresetn(aresetn), .link(link), .address_length_select(wide),
        .quad_command_mode(quad), .half_block_protected(prot), .status1(status1),
        .erase_error(erase_error), .erase_done(erase_done), .array_op(array_op),
        .array_sector(array_sector));
    flash_erase_device #(.BLOCKS(4), .PHASE_CYCLES(4)) u_flash_erase_device_b (.aclk(aclk),
        .aresetn(aresetn), .link(link_b), .address_length_select(wide),
        .quad_command_mode(quad), .half_block_protected(prot), .status1(status1_b),
        .erase_error(), .erase_done(), .array_op(), .array_sector());
    flash_erase_props #(.PHASE_CYCLES(4)) u_flash_erase_props (.aclk(aclk),
        .aresetn(aresetn), .sclk(link.sclk), .cs_n(link.cs_n), .io(link.io),
        .io_oe(link.io_oe), .status1(status1), .erase_error(erase_error),
        .erase_done(erase_done), .array_op(array_op));
    // frame capture on the wire and sector walk tally
    always @(posedge aclk) begin
        if (cs_q && !link.cs_n) begin
            cap = 40'h0;
            nbits = 0;
        end
        if (link.sclk && !sclk_q) begin
            cap = quad ? {cap[35:0], link.io} : {cap[38:0], link.io[0]};
            nbits += quad ? 4 : 1;
        end
        cs_q = link.cs_n;
        sclk_q = link.sclk;
        if (array_op == OP_PREPROGRAM && op_q != OP_PREPROGRAM) begin
            if (n_sect == 0) first_sect = {26'h0, array_sector};
            n_sect++;
        end
        op_q = array_op;
    end
    task automatic check(input string what, input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic expired;
        check("wait bound", 40'h1, 40'h0);
        close_out();
    endtask : expired
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        check("write resp", bresp, RESP_OKAY);
        if (n == 50) expired();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        if (n == 50) expired();
    endtask : axi_rd
    task automatic frame(input logic [7:0] op);
        int n;
        logic seen;
        logic [31:0] d;
        logic [1:0] r;
        seen = 1'b0;
        axi_wr(REG_CMD, {24'h0, op});
        for (n = 0; n < 1000; n++) begin
            axi_rd(REG_STATUS, d, r);
            if (d[0] === 1'b1) seen = 1'b1;
            if (seen && d[0] === 1'b0) break;
        end
        if (n == 1000) expired();
    endtask : frame
    task automatic wait_idle;
        int n;
        for (n = 0; n < 2000; n++) begin
            @(posedge aclk);
            if (status1[STAT_WIP] === 1'b0 && status1_b[STAT_WIP] === 1'b0) break;
        end
        if (n == 2000) expired();
        repeat (2) @(posedge aclk);
    endtask : wait_idle
    task automatic set_mode(input logic w, input logic q);
        wide <= w;
        quad <= q;
        axi_wr(REG_CFG, {30'h0, q, w});
    endtask : set_mode
    task automatic erase_run(input logic [7:0] op, input logic [31:0] adr, input int ab,
            input int first, input int cnt, input logic err);
        logic [39:0] exp;
        exp = (ab == 0) ? {32'h0, op} : (ab == 24) ? {8'h0, op, adr[23:0]} : {op, adr};
        axi_wr(REG_ADDR, adr);
        frame(CMD_WRITE_ENABLE);
        check("latch", status1, 8'h02);
        n_sect = 0;
        frame(op);
        check("frame bits", cap, exp);
        check("bit count", nbits, ab + 8);
        check("busy", status1[STAT_WIP], cnt != 0);
        wait_idle();
        check("sectors", n_sect, cnt);
        if (cnt != 0) check("first sector", first_sect, first);
        check("error", erase_error, err);
        check("status", status1, 8'h00);
    endtask : erase_run
    task automatic no_latch;
        n_sect = 0;
        frame(CMD_BLOCK_ERASE);
        repeat (10) @(posedge aclk);
        check("walk no latch", n_sect, 0);
        check("status no latch", status1, 8'h00);
    endtask : no_latch
    // bench driver for the second link, edges a fixed 3 ns after an aclk rise
    task automatic send_b(input logic [39:0] v, input int nb);
        int i;
        #3 cs_b <= 1'b0;
        for (i = nb - 1; i >= 0; i--) begin
            io_b <= {3'b101, v[i]};
            #80 sclk_b <= 1'b1;
            #80 sclk_b <= 1'b0;
        end
        cs_b <= 1'b1;
        io_b <= ~io_b;
        repeat (8) @(posedge aclk);
    endtask : send_b
    task automatic bad_frames;
        send_b({32'h0, CMD_WRITE_ENABLE}, 8);
        check("latch b", status1_b, 8'h02);
        send_b({31'h0, CMD_CHIP_ERASE_A, 1'b0}, 9);
        check("long chip frame", status1_b, 8'h02);
        send_b({7'h0, CMD_BLOCK_ERASE, 24'h010000, 1'b0}, 33);
        check("long block frame", status1_b, 8'h02);
        send_b({9'h0, CMD_HALF_BLOCK_ERASE, 23'h0}, 31);
        check("short half frame", status1_b, 8'h02);
        send_b({32'h0, CMD_CHIP_ERASE_B}, 8);
        check("chip start b", status1_b, 8'h03);
        wait_idle();
        check("status b", status1_b, 8'h00);
    endtask : bad_frames
    task automatic irq_test;
        logic [31:0] d;
        logic [1:0] r;
        wstrb <= 4'hE;
        axi_wr(REG_CMD, 32'h6);
        wstrb <= 4'hF;
        axi_rd(REG_STATUS, d, r);
        check("strobe ignored", d, 32'h0);
        axi_wr(REG_INT_STAT, 32'h1);
        axi_wr(REG_INT_MASK, 32'h0);
        frame(CMD_WRITE_ENABLE);
        @(posedge aclk);
        check("irq masked", irq, 1'b0);
        axi_rd(REG_INT_STAT, d, r);
        check("int stat", d, 32'h1);
        axi_wr(REG_INT_MASK, 32'h1);
        @(posedge aclk);
        check("irq", irq, 1'b1);
        axi_wr(REG_INT_STAT, 32'h1);
        @(posedge aclk);
        check("irq cleared", irq, 1'b0);
        axi_rd(8'h20, d, r);
        check("unmapped resp", r, RESP_SLVERR);
        check("unmapped data", d, 32'h0);
    endtask : irq_test
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check("reset status", status1, 8'h00);
        check("reset select", link.cs_n, 1'b1);
        erase_run(CMD_HALF_BLOCK_ERASE, 32'h00018000, 24, 24, 8, 1'b0);
        erase_run(CMD_HALF_BLOCK_ERASE_WIDE, 32'h00020000, 32, 32, 8, 1'b0);
        erase_run(CMD_BLOCK_ERASE, 32'h00030000, 24, 48, 16, 1'b0);
        erase_run(CMD_BLOCK_ERASE_WIDE, 32'h00010000, 32, 16, 16, 1'b0);
        set_mode(1'b1, 1'b1);
        erase_run(CMD_HALF_BLOCK_ERASE, 32'h00008000, 32, 8, 8, 1'b0);
        erase_run(CMD_BLOCK_ERASE, 32'h00000000, 32, 0, 16, 1'b0);
        erase_run(CMD_CHIP_ERASE_A, 32'h0, 0, 0, 64, 1'b0);
        prot <= 8'h08;
        erase_run(CMD_HALF_BLOCK_ERASE, 32'h00018000, 32, 0, 0, 1'b1);
        erase_run(CMD_HALF_BLOCK_ERASE, 32'h00010000, 32, 16, 8, 1'b0);
        erase_run(CMD_BLOCK_ERASE_WIDE, 32'h00010000, 32, 0, 0, 1'b1);
        erase_run(CMD_CHIP_ERASE_A, 32'h0, 0, 0, 0, 1'b1);
        prot <= 8'h00;
        set_mode(1'b0, 1'b0);
        no_latch();
        bad_frames();
        irq_test();
        close_out();
    end
endmodule : tb_top
